/* File: hw/sct_pkg.sv */
package sct_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_SR = 8'h08;
  localparam logic [7:0] OFF_OMR = 8'h0C;
  localparam logic [7:0] OFF_A_EXT = 8'h10;
  localparam logic [7:0] OFF_A_LOW = 8'h14;
  localparam logic [7:0] OFF_B_EXT = 8'h18;
  localparam logic [7:0] OFF_B_LOW = 8'h1C;
  localparam logic [7:0] OFF_X0 = 8'h20;
  localparam logic [7:0] OFF_Y0 = 8'h24;
  localparam logic [7:0] OFF_Y1 = 8'h28;
  localparam logic [7:0] OFF_R0 = 8'h2C;
  localparam logic [7:0] OFF_R1 = 8'h30;
  localparam logic [7:0] OFF_N = 8'h34;
  localparam logic [7:0] OFF_MADDR = 8'h38;
  localparam logic [7:0] OFF_MDATA = 8'h3C;
  // status word bits
  localparam int SR_C = 0;
  localparam int SR_V = 1;
  localparam int SR_Z = 2;
  localparam int SR_N = 3;
  localparam int SR_L = 6;
  localparam int SR_SZ = 7;
  localparam int SR_PRIO = 8;
  localparam logic [1:0] PRIO_TRAP = 2'h3;
  localparam logic [15:0] SR_RST = 16'h0300;
  // operating mode word bits
  localparam int OMR_CC = 0;
  localparam int OMR_SA = 1;
  // block status bits
  localparam int ST_BUSY = 0;
  localparam int ST_SVC = 1;
  localparam int ST_TAKEN = 2;
  localparam int ST_ILL = 3;
  // opcodes
  localparam logic [3:0] OPC_TRAP = 4'h1;
  localparam logic [3:0] OPC_TCOND = 4'h2;
  localparam logic [3:0] OPC_TCOPY = 4'h3;
  // condition selections
  localparam logic [3:0] CND_CC = 4'h0;
  localparam logic [3:0] CND_CS = 4'h1;
  localparam logic [3:0] CND_EQ = 4'h2;
  localparam logic [3:0] CND_NE = 4'h3;
  localparam logic [3:0] CND_GE = 4'h4;
  localparam logic [3:0] CND_GT = 4'h5;
  localparam logic [3:0] CND_LE = 4'h6;
  localparam logic [3:0] CND_LT = 4'h7;
  localparam logic [3:0] CND_HS = 4'h8;
  localparam logic [3:0] CND_LO = 4'h9;
  // source and parallel-move register selections
  localparam logic [2:0] SRC_X0 = 3'h0;
  localparam logic [2:0] SRC_Y0 = 3'h1;
  localparam logic [2:0] SRC_Y1 = 3'h2;
  localparam logic [2:0] SRC_A = 3'h3;
  localparam logic [2:0] SRC_B = 3'h4;
  localparam logic [2:0] PM_A1 = 3'h3;
  localparam logic [2:0] PM_B1 = 3'h4;
  localparam logic [2:0] PM_A = 3'h5;
  localparam logic [2:0] PM_B = 3'h6;
  // cycle counts and response codes
  localparam logic [3:0] TRAP_CYC = 4'h8;
  localparam logic [3:0] XFER_CYC = 4'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic pm_post_n;
    logic pm_ptr1;
    logic [2:0] pm_reg;
    logic pm_store;
    logic pm_en;
    logic agu_pair;
    logic dst_b;
    logic [2:0] src;
    logic [3:0] cond;
    logic [3:0] opc;
  } sct_instr_t;

  typedef enum logic {ST_IDLE, ST_RUN} sct_state_t;
endpackage : sct_pkg

/* File: hw/sct_exec.sv */
// Overview of operation
// - decoding the trap op halts sequential issue and enters trap service
// - trap is non-maskable; priority field set to the highest level on entry
// - trap op is one word and takes eight cycles
// - trap op leaves all condition flags unchanged
// - conditional copy writes destination accumulator only when condition is true
// - optional pair copies pointer zero into pointer one under same condition
// - carry and zero conditions: C=0, C=1, Z=1, Z=0
// - signed conditions use N xor V, and Z or (N xor V)
// - higher-or-same and lower aliases only valid with condition mode bit set
// - higher, lower-or-same and normalization conditions are not supported
// - conditional copy reads flags and never writes them
// - pointer written by a move is not used for addressing by the next op
// - conditional copy is one word, two cycles, listed source forms only
// - plain copy moves source into accumulator, all 36 bits between accumulators
// - with saturation enabled the plain copy saturates the moved value
// - plain copy alters only limit and size flags, via its parallel move
// - parallel move does one memory access with post-increment in same op
// - plain copy is one word, two cycles plus parallel move cycles
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sct_exec
  import sct_pkg::*;
#(
  parameter int MOVE_EXTRA = 0,
  parameter int MEM_AW = 4
)(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic busy,
  output logic trap_entry
);
  localparam logic [3:0] MOVE_CYC = 4'(MOVE_EXTRA);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction : hit

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
    begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  function automatic logic [35:0] word36(input logic [15:0] v);
    word36 = {{4{v[15]}}, v, 16'h0000};
  endfunction : word36

  function automatic logic [35:0] sat36(input logic [35:0] v);
    if (v[35:31] == 5'h00 || v[35:31] == 5'h1F)
      sat36 = v;
    else
      sat36 = v[35] ? {4'hF, 32'h8000_0000} : {4'h0, 32'h7FFF_FFFF};
  endfunction : sat36

  // returns {supported, true}
  function automatic logic [1:0] cond_eval(input logic [3:0] c, input logic [15:0] f,
                                           input logic cc_mode);
    logic nv;
    nv = f[SR_N] ^ f[SR_V];
    if (c == CND_CC)
      cond_eval = {1'b1, ~f[SR_C]};
    else if (c == CND_CS)
      cond_eval = {1'b1, f[SR_C]};
    else if (c == CND_EQ)
      cond_eval = {1'b1, f[SR_Z]};
    else if (c == CND_NE)
      cond_eval = {1'b1, ~f[SR_Z]};
    else if (c == CND_GE)
      cond_eval = {1'b1, ~nv};
    else if (c == CND_GT)
      cond_eval = {1'b1, ~(f[SR_Z] | nv)};
    else if (c == CND_LE)
      cond_eval = {1'b1, f[SR_Z] | nv};
    else if (c == CND_LT)
      cond_eval = {1'b1, nv};
    else if (c == CND_HS)
      cond_eval = {cc_mode, ~f[SR_C]};
    else if (c == CND_LO)
      cond_eval = {cc_mode, f[SR_C]};
    else
      cond_eval = 2'b00;
  endfunction : cond_eval

  logic aw_full_reg, w_full_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_en;
  logic [31:0] rd_val;
  logic rd_ok;
  sct_state_t state_reg;
  sct_instr_t ins_reg, ins_wr;
  logic [3:0] cnt_reg, len_reg, len_next;
  logic [15:0] sr_reg, omr_reg, x0_reg, y0_reg, y1_reg, r0_reg, r1_reg, n_reg;
  logic [15:0] r1_prev_reg, maddr_reg;
  logic r1_stale_reg;
  logic [35:0] a_reg, b_reg;
  logic svc_reg, taken_reg, ill_reg;
  logic [15:0] mem [2**MEM_AW];
  logic start, commit, opc_ok;
  logic [1:0] cnd;
  logic take, acc_we, pm_we_mem;
  logic [35:0] xfer_val, pm_acc;
  logic [15:0] ptr_use, pm_data, ptr_inc;
  logic pm_lim, pm_sz;

  assign wr_en = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign ins_wr = sct_instr_t'(wdata_reg[$bits(sct_instr_t)-1:0]);
  assign opc_ok = ins_wr.opc == OPC_TRAP || ins_wr.opc == OPC_TCOND
                  || ins_wr.opc == OPC_TCOPY;
  // new ops refused while busy or while trap service is open
  assign start = wr_en && hit(awaddr_reg, OFF_INSTR) && state_reg == ST_IDLE
                 && !svc_reg && opc_ok;
  assign commit = state_reg == ST_RUN && cnt_reg == len_reg - 4'h1;

  // write address and data captured independently, either order
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_full_reg <= 1'b0;
      s_axi_awready <= 1'b1;
      awaddr_reg <= 8'h00;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        s_axi_awready <= 1'b0;
        awaddr_reg <= s_axi_awaddr;
      end
      else if (wr_en)
      begin
        aw_full_reg <= 1'b0;
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      w_full_reg <= 1'b0;
      s_axi_wready <= 1'b1;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      else if (wr_en)
      begin
        w_full_reg <= 1'b0;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (wr_en)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_reg < 8'h40) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_comb
  begin
    rd_ok = 1'b1;
    if (hit(s_axi_araddr, OFF_STATUS))
      rd_val = {28'h0, ill_reg, taken_reg, svc_reg, state_reg == ST_RUN};
    else if (hit(s_axi_araddr, OFF_SR))
      rd_val = {16'h0, sr_reg};
    else if (hit(s_axi_araddr, OFF_OMR))
      rd_val = {16'h0, omr_reg};
    else if (hit(s_axi_araddr, OFF_A_EXT))
      rd_val = {28'h0, a_reg[35:32]};
    else if (hit(s_axi_araddr, OFF_A_LOW))
      rd_val = a_reg[31:0];
    else if (hit(s_axi_araddr, OFF_B_EXT))
      rd_val = {28'h0, b_reg[35:32]};
    else if (hit(s_axi_araddr, OFF_B_LOW))
      rd_val = b_reg[31:0];
    else if (hit(s_axi_araddr, OFF_X0))
      rd_val = {16'h0, x0_reg};
    else if (hit(s_axi_araddr, OFF_Y0))
      rd_val = {16'h0, y0_reg};
    else if (hit(s_axi_araddr, OFF_Y1))
      rd_val = {16'h0, y1_reg};
    else if (hit(s_axi_araddr, OFF_R0))
      rd_val = {16'h0, r0_reg};
    else if (hit(s_axi_araddr, OFF_R1))
      rd_val = {16'h0, r1_reg};
    else if (hit(s_axi_araddr, OFF_N))
      rd_val = {16'h0, n_reg};
    else if (hit(s_axi_araddr, OFF_MADDR))
      rd_val = {16'h0, maddr_reg};
    else if (hit(s_axi_araddr, OFF_MDATA))
      rd_val = {16'h0, mem[maddr_reg[MEM_AW-1:0]]};
    else
    begin
      rd_val = 32'h0000_0000;
      rd_ok = hit(s_axi_araddr, OFF_INSTR);
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  always_comb
  begin
    if (ins_wr.opc == OPC_TRAP)
      len_next = TRAP_CYC;
    else if (ins_wr.opc == OPC_TCOPY && ins_wr.pm_en)
      len_next = XFER_CYC + MOVE_CYC;
    else
      len_next = XFER_CYC;
  end

  // sequencer: every op holds its full slot, even a false condition
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      ins_reg <= '0;
      cnt_reg <= 4'h0;
      len_reg <= XFER_CYC;
    end
    else if (ce)
    begin
      case (state_reg)
        ST_IDLE:
          if (start)
          begin
            state_reg <= ST_RUN;
            ins_reg <= ins_wr;
            cnt_reg <= 4'h0;
            len_reg <= len_next;
          end
        ST_RUN:
          if (commit)
            state_reg <= ST_IDLE;
          else
            cnt_reg <= cnt_reg + 4'h1;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // execution datapath, evaluated in the final cycle of the slot
  always_comb
  begin
    cnd = cond_eval(ins_reg.cond, sr_reg, omr_reg[OMR_CC]);
    take = commit && ins_reg.opc == OPC_TCOND && cnd == 2'b11;
    if (ins_reg.src == SRC_Y0)
      xfer_val = word36(y0_reg);
    else if (ins_reg.src == SRC_Y1)
      xfer_val = word36(y1_reg);
    else if (ins_reg.src == SRC_A)
      xfer_val = a_reg;
    else if (ins_reg.src == SRC_B)
      xfer_val = b_reg;
    else
      xfer_val = word36(x0_reg);
    if (ins_reg.opc == OPC_TCOPY && omr_reg[OMR_SA])
      xfer_val = sat36(xfer_val);
    acc_we = take || (commit && ins_reg.opc == OPC_TCOPY);
    // pointer one just written by a pair copy still addresses with its old value
    if (ins_reg.pm_ptr1)
      ptr_use = r1_stale_reg ? r1_prev_reg : r1_reg;
    else
      ptr_use = r0_reg;
    ptr_inc = ptr_use + (ins_reg.pm_post_n ? n_reg : 16'h0001);
    pm_acc = (ins_reg.pm_reg == PM_B || ins_reg.pm_reg == PM_B1) ? b_reg : a_reg;
    pm_lim = 1'b0;
    pm_sz = 1'b0;
    if (ins_reg.pm_reg == SRC_X0)
      pm_data = x0_reg;
    else if (ins_reg.pm_reg == SRC_Y0)
      pm_data = y0_reg;
    else if (ins_reg.pm_reg == SRC_Y1)
      pm_data = y1_reg;
    else if (ins_reg.pm_reg == PM_A1 || ins_reg.pm_reg == PM_B1)
      pm_data = pm_acc[31:16];
    else
    begin
      // full accumulator stores limit when extension holds magnitude
      pm_sz = pm_acc[30] ^ pm_acc[29];
      if (pm_acc[35:31] != 5'h00 && pm_acc[35:31] != 5'h1F)
      begin
        pm_lim = 1'b1;
        pm_data = pm_acc[35] ? 16'h8000 : 16'h7FFF;
      end
      else
        pm_data = pm_acc[31:16];
    end
    pm_we_mem = commit && ins_reg.opc == OPC_TCOPY && ins_reg.pm_en;
  end

  // store path to memory; a parallel store outranks a software write
  always_ff @(posedge sys_clk)
  begin
    if (ce)
    begin
      if (pm_we_mem && ins_reg.pm_store)
        mem[ptr_use[MEM_AW-1:0]] <= pm_data;
      else if (wr_en && hit(awaddr_reg, OFF_MDATA))
        mem[maddr_reg[MEM_AW-1:0]] <= wdata_reg[15:0];
    end
  end

  // loads from memory land after the copy, so a load into the same
  // accumulator wins over the copy
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      a_reg <= 36'h0_0000_0000;
      b_reg <= 36'h0_0000_0000;
      x0_reg <= 16'h0000;
      y0_reg <= 16'h0000;
      y1_reg <= 16'h0000;
    end
    else if (ce)
    begin
      if (wr_en && hit(awaddr_reg, OFF_A_EXT) && wstrb_reg[0])
        a_reg[35:32] <= wdata_reg[3:0];
      if (wr_en && hit(awaddr_reg, OFF_A_LOW))
        a_reg[31:0] <= merge(a_reg[31:0], wdata_reg, wstrb_reg);
      if (wr_en && hit(awaddr_reg, OFF_B_EXT) && wstrb_reg[0])
        b_reg[35:32] <= wdata_reg[3:0];
      if (wr_en && hit(awaddr_reg, OFF_B_LOW))
        b_reg[31:0] <= merge(b_reg[31:0], wdata_reg, wstrb_reg);
      if (wr_en && hit(awaddr_reg, OFF_X0))
        x0_reg <= 16'(merge({16'h0, x0_reg}, wdata_reg, wstrb_reg));
      if (wr_en && hit(awaddr_reg, OFF_Y0))
        y0_reg <= 16'(merge({16'h0, y0_reg}, wdata_reg, wstrb_reg));
      if (wr_en && hit(awaddr_reg, OFF_Y1))
        y1_reg <= 16'(merge({16'h0, y1_reg}, wdata_reg, wstrb_reg));
      if (acc_we && !ins_reg.dst_b)
        a_reg <= xfer_val;
      if (acc_we && ins_reg.dst_b)
        b_reg <= xfer_val;
      if (pm_we_mem && !ins_reg.pm_store)
      begin
        if (ins_reg.pm_reg == SRC_X0)
          x0_reg <= mem[ptr_use[MEM_AW-1:0]];
        else if (ins_reg.pm_reg == SRC_Y0)
          y0_reg <= mem[ptr_use[MEM_AW-1:0]];
        else if (ins_reg.pm_reg == SRC_Y1)
          y1_reg <= mem[ptr_use[MEM_AW-1:0]];
        else if (ins_reg.pm_reg == PM_A1)
          a_reg[31:16] <= mem[ptr_use[MEM_AW-1:0]];
        else if (ins_reg.pm_reg == PM_B1)
          b_reg[31:16] <= mem[ptr_use[MEM_AW-1:0]];
        else if (ins_reg.pm_reg == PM_A)
          a_reg <= word36(mem[ptr_use[MEM_AW-1:0]]);
        else if (ins_reg.pm_reg == PM_B)
          b_reg <= word36(mem[ptr_use[MEM_AW-1:0]]);
      end
    end
  end

  // address pointers and the one-op delay on a moved pointer
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      r0_reg <= 16'h0000;
      r1_reg <= 16'h0000;
      n_reg <= 16'h0000;
      r1_prev_reg <= 16'h0000;
      r1_stale_reg <= 1'b0;
      maddr_reg <= 16'h0000;
    end
    else if (ce)
    begin
      if (wr_en && hit(awaddr_reg, OFF_R0))
        r0_reg <= 16'(merge({16'h0, r0_reg}, wdata_reg, wstrb_reg));
      if (wr_en && hit(awaddr_reg, OFF_R1))
        r1_reg <= 16'(merge({16'h0, r1_reg}, wdata_reg, wstrb_reg));
      if (wr_en && hit(awaddr_reg, OFF_N))
        n_reg <= 16'(merge({16'h0, n_reg}, wdata_reg, wstrb_reg));
      if (wr_en && hit(awaddr_reg, OFF_MADDR))
        maddr_reg <= 16'(merge({16'h0, maddr_reg}, wdata_reg, wstrb_reg));
      if (commit)
        r1_stale_reg <= 1'b0;
      if (pm_we_mem && !ins_reg.pm_ptr1)
        r0_reg <= ptr_inc;
      if (pm_we_mem && ins_reg.pm_ptr1)
        r1_reg <= ptr_inc;
      if (take && ins_reg.agu_pair)
      begin
        r1_reg <= r0_reg;
        r1_prev_reg <= r1_reg;
        r1_stale_reg <= 1'b1;
      end
    end
  end

  // flags: the conditional copy and the trap never write them
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sr_reg <= SR_RST;
      omr_reg <= 16'h0000;
    end
    else if (ce)
    begin
      if (wr_en && hit(awaddr_reg, OFF_SR))
        sr_reg <= 16'(merge({16'h0, sr_reg}, wdata_reg, wstrb_reg));
      if (wr_en && hit(awaddr_reg, OFF_OMR))
        omr_reg <= 16'(merge({16'h0, omr_reg}, wdata_reg, wstrb_reg));
      if (commit && ins_reg.opc == OPC_TRAP)
        sr_reg[SR_PRIO +: 2] <= PRIO_TRAP;
      if (pm_we_mem && pm_lim)
        sr_reg[SR_L] <= 1'b1;
      if (pm_we_mem && pm_sz)
        sr_reg[SR_SZ] <= 1'b1;
    end
  end

  // sticky service and illegal status, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      svc_reg <= 1'b0;
      taken_reg <= 1'b0;
      ill_reg <= 1'b0;
      trap_entry <= 1'b0;
      busy <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_en && hit(awaddr_reg, OFF_STATUS) && wdata_reg[ST_SVC])
        svc_reg <= 1'b0;
      if (wr_en && hit(awaddr_reg, OFF_STATUS) && wdata_reg[ST_ILL])
        ill_reg <= 1'b0;
      if (commit && ins_reg.opc == OPC_TRAP)
        svc_reg <= 1'b1;
      if (commit && ins_reg.opc == OPC_TCOND)
        taken_reg <= take;
      if (commit && ins_reg.opc == OPC_TCOND && !cnd[1])
        ill_reg <= 1'b1;
      if (wr_en && hit(awaddr_reg, OFF_INSTR) && !opc_ok)
        ill_reg <= 1'b1;
      trap_entry <= commit && ins_reg.opc == OPC_TRAP;
      busy <= start || (state_reg == ST_RUN && !commit);
    end
  end
endmodule : sct_exec
`default_nettype wire

/* File: tb/sct_exec_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sct_exec_chk
  import sct_pkg::*;
#(
  parameter int MOVE_EXTRA = 0
)(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic busy,
  input wire logic trap_entry
);
  logic [4:0] run_reg;
  logic [4:0] last_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // counts only enabled cycles, since ce low freezes busy
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) run_reg <= 5'h00;
    else if (ce) run_reg <= busy ? run_reg + 5'h01 : 5'h00;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) last_reg <= 5'h00;
    else if (ce && !busy && run_reg != 5'h00) last_reg <= run_reg;
  property p_run_len;
    ce && !busy && run_reg != 5'h00 |->
      run_reg == 5'h02 || run_reg == 5'h08 || run_reg == 5'(2 + MOVE_EXTRA);
  endproperty
  a_run_len: assert property (p_run_len) else $error("op slot length wrong");
  property p_busy_max; run_reg <= 5'(8 + MOVE_EXTRA); endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy too long");
  property p_trap_len; trap_entry |-> run_reg == 5'h08 || last_reg == 5'h08; endproperty
  a_trap_len: assert property (p_trap_len) else $error("trap slot not 8");
  property p_trap_pulse; trap_entry && ce |=> !trap_entry; endproperty
  a_trap_pulse: assert property (p_trap_pulse) else $error("trap pulse too wide");
  property p_b_hold; s_axi_bvalid && !s_axi_bready && ce |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready && ce |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_b_code; s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR;
  endproperty
  a_b_code: assert property (p_b_code) else $error("bad write response code");
  property p_w_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_w_ans: assert property (p_w_ans) else $error("write not answered");
  property p_r_ans; s_axi_arvalid && s_axi_arready && ce |-> ##[1:2] s_axi_rvalid; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read not answered");
  c_trap: cover property (trap_entry);
  c_short: cover property (ce && !busy && run_reg == 5'h02);
  c_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : sct_exec_chk
bind sct_exec sct_exec_chk #(.MOVE_EXTRA(MOVE_EXTRA)) u_chk (.sys_clk, .rst, .ce,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .busy, .trap_entry);
`default_nettype wire

/* File: tb/sct_exec_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sct_exec_tb import sct_pkg::*;;
  logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_val;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, busy, trap_entry;
  logic [1:0] bresp, rresp, resp;
  int num_errors = 0, n_tests = 0;
  sct_exec dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .busy(busy), .trap_entry(trap_entry));
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic hang(input int n, input int lim);
    if (n >= lim)
    begin
      num_errors++;
      $display("BAD %0t wait ran out", $time);
      final_report();
    end
  endtask : hang
  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
    hang(n, 100);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd_val = rdata;
    resp = rresp;
    rready <= 1'b0;
    hang(n, 100);
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_val, exp);
  endtask : rdc
  task automatic run_op(input logic [31:0] i);
    int n;
    wr(OFF_INSTR, i);
    for (n = 0; n < 5 && !busy; n++) @(posedge sys_clk);
    for (n = 0; n < 20 && busy; n++) @(posedge sys_clk);
    hang(n, 20);
  endtask : run_op
  function automatic logic cok(input int c, input logic [3:0] f, input logic m);
    logic nv;
    nv = f[SR_N] ^ f[SR_V];
    case (c)
      0: cok = !f[SR_C];
      1: cok = f[SR_C];
      2: cok = f[SR_Z];
      3: cok = !f[SR_Z];
      4: cok = !nv;
      5: cok = !(f[SR_Z] | nv);
      6: cok = f[SR_Z] | nv;
      7: cok = nv;
      8: cok = m && !f[SR_C];
      9: cok = m && f[SR_C];
      default: cok = 1'b0;
    endcase
  endfunction : cok
  task automatic t_reset;
    rdc(OFF_SR, 32'(SR_RST));
    rd(8'h40);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(8'h44, 32'h1);
    chk(32'(resp), 32'(RESP_SLVERR));
    $display("reset and map done");
  endtask : t_reset
  task automatic t_trap;
    int n;
    wr(OFF_SR, 32'h0000000B);
    wr(OFF_INSTR, 32'(OPC_TRAP));
    for (n = 0; n < 30 && !trap_entry; n++) @(posedge sys_clk);
    hang(n, 30);
    rdc(OFF_SR, 32'h0000030B);
    rdc(OFF_STATUS, 32'h2);
    wr(OFF_STATUS, 32'h2);
    rdc(OFF_STATUS, 32'h0);
    $display("trap done");
  endtask : t_trap
  // every condition against every flag pattern, alias mode off and on
  task automatic t_cond;
    int c, m, f;
    logic ok;
    wr(OFF_B_EXT, 32'h5);
    wr(OFF_B_LOW, 32'h13579BDF);
    wr(OFF_R0, 32'h00AA);
    for (m = 0; m < 2; m++)
    begin
      wr(OFF_OMR, 32'(m));
      for (c = 0; c < 11; c++)
        for (f = 0; f < 16; f++)
        begin
          wr(OFF_A_EXT, 32'h0);
          wr(OFF_A_LOW, 32'h2468ACE0);
          wr(OFF_R1, 32'h0055);
          wr(OFF_SR, 32'(f));
          run_op({19'h0, 1'b1, 1'b0, SRC_B, c[3:0], OPC_TCOND});
          ok = cok(c, f[3:0], m[0]);
          rdc(OFF_A_EXT, ok ? 32'h5 : 32'h0);
          rdc(OFF_A_LOW, ok ? 32'h13579BDF : 32'h2468ACE0);
          rdc(OFF_R1, ok ? 32'h00AA : 32'h0055);
          rdc(OFF_SR, 32'(f));
          rd(OFF_STATUS);
          if (c == 10) chk(32'(rd_val[ST_ILL]), 32'h1);
          wr(OFF_STATUS, 32'h8);
        end
    end
    $display("conditional copy done");
  endtask : t_cond
  task automatic t_copy;
    wr(OFF_B_EXT, 32'hA);
    wr(OFF_B_LOW, 32'hCCCCEEEE);
    wr(OFF_SR, 32'hF);
    wr(OFF_OMR, 32'h0);
    run_op({20'h0, 1'b0, SRC_B, 4'h0, OPC_TCOPY});
    rdc(OFF_A_EXT, 32'hA);
    rdc(OFF_A_LOW, 32'hCCCCEEEE);
    rdc(OFF_SR, 32'hF);
    wr(OFF_OMR, 32'h2);
    run_op({20'h0, 1'b0, SRC_B, 4'h0, OPC_TCOPY});
    rdc(OFF_A_EXT, 32'hF);
    rdc(OFF_A_LOW, 32'h80000000);
    wr(OFF_OMR, 32'h0);
    wr(OFF_MADDR, 32'h3);
    wr(OFF_MDATA, 32'h1234);
    wr(OFF_R0, 32'h3);
    run_op({12'h0, 2'b00, SRC_X0, 3'b010, 1'b0, SRC_B, 4'h0, OPC_TCOPY});
    rdc(OFF_X0, 32'h1234);
    rdc(OFF_R0, 32'h4);
    rdc(OFF_A_LOW, 32'hCCCCEEEE);
    // pair copy moves ptr1 to 4, next store must still address with old 7
    wr(OFF_R1, 32'h7);
    run_op({19'h0, 1'b1, 1'b1, SRC_A, CND_CS, OPC_TCOND});
    run_op({12'h0, 2'b01, PM_A, 3'b110, 1'b0, SRC_A, 4'h0, OPC_TCOPY});
    wr(OFF_MADDR, 32'h7);
    rdc(OFF_MDATA, 32'h8000);
    rdc(OFF_R1, 32'h8);
    rdc(OFF_SR, 32'hCF);
    $display("plain copy done");
  endtask : t_copy
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_trap();
    t_cond();
    t_copy();
    final_report();
  end
endmodule : sct_exec_tb
`default_nettype wire
